//--- design/sbcg_core.sv
// apb-controlled baud clock generator with transfer clock pin handling
//
// Local design decisions: the APB interface to the registers and the register addresses.
module sbcg_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xck_i,
	output logic             xck_o,
	output logic             xck_oe,
	output logic             txclk,
	output logic             rxclk,
	output logic             sync_change,
	output logic             sync_sample,
	output logic      [4:0]  rx_states
);
	logic [3:0]              ctrl;
	logic [7:0]              div_low;
	logic [3:0]              div_high;
	logic [3:0]              next_ctrl;
	logic [7:0]              next_div_low;
	logic [3:0]              next_div_high;
	logic                    next_pready;
	logic [31:0]             next_prdata;
	logic                    next_pslverr;
	logic [11:0]             bcnt;
	logic [11:0]             next_bcnt;
	logic [3:0]              pre;
	logic [3:0]              next_pre;
	logic                    xck_q;
	logic                    next_xck_q;
	logic                    s1;
	logic                    s2;
	logic                    s3;
	logic                    next_txclk;
	logic                    next_rxclk;
	logic                    next_change;
	logic                    next_sample;
	logic                    next_oe;
	logic [4:0]              next_rx_states;
	logic [11:0]             divisor;
	logic                    tick;
	logic                    low_wr;
	logic                    wr_en;
	logic                    rd_go;
	logic                    pol;
	logic                    rise;
	logic                    fall;
	logic [4:0]              tx_div;
	sbcg_pkg::sbcg_mode_t    mode;

	assign divisor = {div_high, div_low};
	assign pol     = ctrl[sbcg_pkg::CTRL_POL];
	assign wr_en   = psel & penable & pready & pwrite;
	assign rd_go   = psel & penable & ~pready & ~pwrite;
	assign low_wr  = wr_en & (paddr == sbcg_pkg::ADDR_DIV_LOW);
	assign tick    = (bcnt == 12'h000);
	assign rise    = s2 & ~s3;
	assign fall    = ~s2 & s3;

	// mode decode; double speed only counts when asynchronous
	always_comb begin
		if (!ctrl[sbcg_pkg::CTRL_SYNC]) begin
			if (ctrl[sbcg_pkg::CTRL_DOUBLE]) begin
				mode = sbcg_pkg::MODE_DOUBLE;
			end else begin
				mode = sbcg_pkg::MODE_ASYNC;
			end
		end else if (ctrl[sbcg_pkg::CTRL_DIR]) begin
			mode = sbcg_pkg::MODE_MASTER;
		end else begin
			mode = sbcg_pkg::MODE_SLAVE;
		end
	end

	// apb slave: one wait state, answer registered
	always_comb begin
		next_ctrl     = ctrl;
		next_div_low  = div_low;
		next_div_high = div_high;
		next_pready   = psel & penable & ~pready;
		next_prdata   = 32'h0000_0000;
		next_pslverr  = 1'b0;
		if (wr_en) begin
			case (paddr)
				sbcg_pkg::ADDR_CTRL: begin
					next_ctrl = pwdata[3:0];
				end
				sbcg_pkg::ADDR_DIV_LOW: begin
					next_div_low = pwdata[7:0];
				end
				sbcg_pkg::ADDR_DIV_HIGH: begin
					next_div_high = pwdata[3:0];
				end
				default: begin
					next_ctrl = ctrl;
				end
			endcase
		end
		if (psel & penable & ~pready) begin
			case (paddr)
				sbcg_pkg::ADDR_CTRL,
				sbcg_pkg::ADDR_DIV_LOW,
				sbcg_pkg::ADDR_DIV_HIGH: begin
					next_pslverr = 1'b0;
				end
				sbcg_pkg::ADDR_STATUS: begin
					next_pslverr = pwrite;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		if (rd_go) begin
			case (paddr)
				sbcg_pkg::ADDR_CTRL: begin
					next_prdata[3:0] = ctrl;
				end
				sbcg_pkg::ADDR_DIV_LOW: begin
					next_prdata[7:0] = div_low;
				end
				sbcg_pkg::ADDR_DIV_HIGH: begin
					next_prdata[3:0] = div_high;
				end
				sbcg_pkg::ADDR_STATUS: begin
					next_prdata[11:0] = bcnt;
					next_prdata[sbcg_pkg::ST_MODE_LSB +: 2] = mode;
					next_prdata[sbcg_pkg::ST_XCK] = xck_q;
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= sbcg_pkg::CTRL_RESET;
			div_low  <= sbcg_pkg::DIV_LOW_RESET;
			div_high <= sbcg_pkg::DIV_HIGH_RESET;
			pready   <= 1'b0;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
		end else begin
			ctrl     <= next_ctrl;
			div_low  <= next_div_low;
			div_high <= next_div_high;
			pready   <= next_pready;
			prdata   <= next_prdata;
			pslverr  <= next_pslverr;
		end
	end

	// baud down-counter, transmit prescaler and master clock
	always_comb begin
		next_bcnt  = bcnt - 12'h001;
		next_pre   = pre;
		next_xck_q = xck_q;
		if (low_wr) begin
			next_bcnt = {div_high, pwdata[7:0]};
		end else if (tick) begin
			next_bcnt = divisor;
		end
		if (mode == sbcg_pkg::MODE_DOUBLE) begin
			tx_div = sbcg_pkg::TX_DIV_DOUBLE;
		end else begin
			tx_div = sbcg_pkg::TX_DIV_NORMAL;
		end
		if (ctrl[sbcg_pkg::CTRL_SYNC]) begin
			next_pre = 4'h0;
		end else if (tick) begin
			if ({1'b0, pre} == tx_div - 5'h01) begin
				next_pre = 4'h0;
			end else begin
				next_pre = pre + 4'h1;
			end
		end
		// idle level follows polarity so the first edge is a change edge
		if (mode != sbcg_pkg::MODE_MASTER) begin
			next_xck_q = pol;
		end else if (tick) begin
			next_xck_q = ~xck_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt  <= 12'h000;
			pre   <= 4'h0;
			xck_q <= 1'b0;
		end else begin
			bcnt  <= next_bcnt;
			pre   <= next_pre;
			xck_q <= next_xck_q;
		end
	end

	// s1 feeds only s2; edges are taken between s2 and s3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= xck_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// clock enables toward transmitter and receiver
	always_comb begin
		next_txclk     = 1'b0;
		next_rxclk     = 1'b0;
		next_change    = 1'b0;
		next_sample    = 1'b0;
		next_oe        = 1'b0;
		next_rx_states = sbcg_pkg::RX_ST_NORMAL;
		case (mode)
			sbcg_pkg::MODE_ASYNC: begin
				next_rxclk = tick;
				next_txclk = tick & ({1'b0, pre} == tx_div - 5'h01);
			end
			sbcg_pkg::MODE_DOUBLE: begin
				next_rxclk     = tick;
				next_txclk     = tick & ({1'b0, pre} == tx_div - 5'h01);
				next_rx_states = sbcg_pkg::RX_ST_DOUBLE;
			end
			sbcg_pkg::MODE_MASTER: begin
				next_oe        = 1'b1;
				next_rxclk     = tick;
				next_change    = tick & (xck_q == pol);
				next_sample    = tick & (xck_q != pol);
				next_txclk     = next_change;
				next_rx_states = sbcg_pkg::RX_ST_SYNC;
			end
			sbcg_pkg::MODE_SLAVE: begin
				// an edge every cycle is followed; the two-cycle pipeline only adds delay
				next_change    = pol ? fall : rise;
				next_sample    = pol ? rise : fall;
				next_rxclk     = rise | fall;
				next_txclk     = next_change;
				next_rx_states = sbcg_pkg::RX_ST_SYNC;
			end
			default: begin
				next_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txclk       <= 1'b0;
			rxclk       <= 1'b0;
			sync_change <= 1'b0;
			sync_sample <= 1'b0;
			xck_oe      <= 1'b0;
			xck_o       <= 1'b0;
			rx_states   <= sbcg_pkg::RX_ST_NORMAL;
		end else begin
			txclk       <= next_txclk;
			rxclk       <= next_rxclk;
			sync_change <= next_change;
			sync_sample <= next_sample;
			xck_oe      <= next_oe;
			xck_o       <= next_xck_q & next_oe;
			rx_states   <= next_rx_states;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_zero_reload: assert property (tick && !low_wr |=> bcnt == $past(divisor))
		else $error("counter did not reload at zero");
	a_low_reload: assert property (low_wr |=> bcnt == {div_high, $past(pwdata[7:0])})
		else $error("low write did not reload counter");
	a_count_down: assert property (!tick && !low_wr |=> bcnt == $past(bcnt) - 12'h001)
		else $error("counter did not step down");
	a_baud_pulse: assert property (tick && mode != sbcg_pkg::MODE_SLAVE |=> rxclk)
		else $error("no receive pulse at counter zero");
	a_rx_gap: assert property (rxclk && mode == sbcg_pkg::MODE_ASYNC && divisor == 12'h001
		&& $stable(divisor) |=> !rxclk)
		else $error("receive pulses too close");
	a_tx_div: assert property (tick && !ctrl[sbcg_pkg::CTRL_SYNC]
		&& pre == 4'hf && mode == sbcg_pkg::MODE_ASYNC |=> txclk)
		else $error("transmit pulse missing after sixteen ticks");
	a_pin_async: assert property (!ctrl[sbcg_pkg::CTRL_SYNC] |=> !xck_oe && !xck_o)
		else $error("clock pin driven in async mode");
	a_pin_master: assert property (mode == sbcg_pkg::MODE_MASTER |=> xck_oe)
		else $error("master does not drive clock pin");
	a_sync_states: assert property (ctrl[sbcg_pkg::CTRL_SYNC]
		|=> rx_states == sbcg_pkg::RX_ST_SYNC)
		else $error("double speed leaked into sync mode");
	a_slave_edge: assert property (mode == sbcg_pkg::MODE_SLAVE && !pol
		&& $rose(s2) |=> txclk && !sync_sample)
		else $error("slave change edge not seen");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");

	c_normal_tx: cover property (mode == sbcg_pkg::MODE_ASYNC && txclk);
	c_double_tx: cover property (mode == sbcg_pkg::MODE_DOUBLE && txclk);
	c_master_clk: cover property (xck_oe && $rose(xck_o));
	c_slave_edge: cover property (mode == sbcg_pkg::MODE_SLAVE && sync_sample);
endmodule : sbcg_core

//--- include/sbcg_pkg.sv
// constants and types of the serial port baud clock generator
// How it works
// - four clock modes, sync select picks async/sync
// - in sync, pin direction picks master/slave
// - double speed ignored in synchronous modes
// - clock pin idle in asynchronous modes
// - down-counter reloads at zero, low write
// - one baud pulse per counter zero
// - transmit clock is baud divided 2/8/16
// - receive clock is baud pulse, 2/8/16 states
// - normal async rate is fosc/(16(div+1))
// - double async rate is fosc/(8(div+1))
// - master rate is fosc/(2(div+1))
// - divisor is twelve bits, high plus low
// - double speed gives eight samples per bit
// - baud generator clocks all but slave mode
// - master drives clock pin, slave reads it
// - external clock synchronised, edge detected, two cycles
// - polarity chooses change and sample edges
package sbcg_pkg;
	localparam int DIV_W = 12;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV_LOW = 8'h04;
	localparam logic [7:0] ADDR_DIV_HIGH = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_DOUBLE = 1;
	localparam int CTRL_DIR = 2;
	localparam int CTRL_POL = 3;
	localparam int CTRL_W = 4;
	localparam int HIGH_W = 4;
	localparam int ST_MODE_LSB = 12;
	localparam int ST_XCK = 14;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [7:0] DIV_LOW_RESET = 8'h00;
	localparam logic [3:0] DIV_HIGH_RESET = 4'h0;
	localparam logic [4:0] TX_DIV_NORMAL = 5'h10;
	localparam logic [4:0] TX_DIV_DOUBLE = 5'h08;
	localparam logic [4:0] RX_ST_NORMAL = 5'h10;
	localparam logic [4:0] RX_ST_DOUBLE = 5'h08;
	localparam logic [4:0] RX_ST_SYNC = 5'h02;
	typedef enum logic [1:0] {
		MODE_ASYNC  = 2'b00,
		MODE_DOUBLE = 2'b01,
		MODE_MASTER = 2'b11,
		MODE_SLAVE  = 2'b10
	} sbcg_mode_t;
endpackage : sbcg_pkg

//--- testbench/sbcg_core_tb_top.sv
// self-checking bench for the baud clock generator
module sbcg_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, half;
	logic [31:0] pwdata, prdata, rd;
	logic        xck_o, xck_oe, txclk, rxclk, sync_change, sync_sample, pin_drv, part_en;
	logic [4:0]  rx_states;
	logic [3:0]  vec;
	wire logic   xck_pin;
	int          err_total, samples_checked, g;
	assign xck_pin = xck_oe ? xck_o : pin_drv;
	assign vec = {sync_sample, sync_change, rxclk, txclk};
	sbcg_core sbcg_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xck_i(xck_pin), .xck_o(xck_o), .xck_oe(xck_oe), .txclk(txclk),
		.rxclk(rxclk), .sync_change(sync_change), .sync_sample(sync_sample),
		.rx_states(rx_states));
	sbcg_xck_partner sbcg_xck_partner_inst (.pclk(pclk), .en(part_en), .half(half),
		.xck(pin_drv));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	// skips the first pulse after a mode change, which may still carry the old setting
	task automatic gap(input int sel, output int cyc);
		int n, k;
		n = 0;
		k = 0;
		cyc = 0;
		while (k < 3 && n < 1000) begin
			@(posedge pclk);
			n++;
			if (k >= 2) cyc++;
			if (vec[sel] === 1'b1) k++;
		end
		if (n >= 1000) begin
			err_total++;
			end_of_test();
		end
	endtask : gap
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		part_en = 1'b0;
		half = 8'h04;
		err_total = 0;
		samples_checked = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(rx_states), 32'h10);
		for (int a = 0; a < 3; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, sbcg_pkg::ADDR_STATUS, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, sbcg_pkg::ADDR_DIV_LOW, 32'h1);
		gap(0, g);
		chk(g, 32);
		gap(1, g);
		chk(g, 2);
		chk(32'(xck_oe), 32'h0);
		apb(1'b1, sbcg_pkg::ADDR_DIV_HIGH, 32'h1);
		apb(1'b1, sbcg_pkg::ADDR_DIV_LOW, 32'h0);
		gap(1, g);
		chk(g, 257);
		apb(1'b1, sbcg_pkg::ADDR_DIV_HIGH, 32'h0);
		apb(1'b1, sbcg_pkg::ADDR_DIV_LOW, 32'h1);
		apb(1'b1, sbcg_pkg::ADDR_CTRL, 32'h2);
		gap(0, g);
		chk(g, 16);
		chk(32'(rx_states), 32'h8);
		// master, polarity 0; software keeps double speed clear in sync modes
		apb(1'b1, sbcg_pkg::ADDR_CTRL, 32'h5);
		gap(0, g);
		chk(g, 4);
		gap(1, g);
		chk(g, 2);
		chk(32'(rx_states), 32'h2);
		chk(32'(xck_oe), 32'h1);
		gap(2, g);
		chk(32'(xck_o), 32'h1);
		gap(3, g);
		chk(32'(xck_o), 32'h0);
		apb(1'b0, sbcg_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[13:12]), 32'h3);
		apb(1'b1, sbcg_pkg::ADDR_CTRL, 32'hd);
		gap(2, g);
		chk(32'(xck_o), 32'h0);
		part_en <= 1'b1;
		apb(1'b1, sbcg_pkg::ADDR_CTRL, 32'h1);
		gap(0, g);
		chk(g, 8);
		gap(1, g);
		chk(g, 4);
		chk(32'(xck_oe), 32'h0);
		apb(1'b0, sbcg_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[13:12]), 32'h2);
		end_of_test();
	end
endmodule : sbcg_core_tb_top

//--- testbench/sbcg_xck_partner.sv
// remote serial device model that supplies the transfer clock in slave mode
module sbcg_xck_partner (
	input  wire logic       pclk,
	input  wire logic       en,
	input  wire logic [7:0] half,
	output logic            xck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		xck = 1'b0;
	end
	// released line toggles every cycle so that any stray sampling shows
	always @(posedge pclk) begin
		if (!en) begin
			xck <= ~xck;
			cnt <= 8'h00;
		end else if (cnt == half - 8'h01) begin
			xck <= ~xck;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : sbcg_xck_partner
